/* hdl/pwsec_map.svh */
// register offsets, field positions, reset values and command codes of the password block
`ifndef PWSEC_MAP_SVH
`define PWSEC_MAP_SVH

`define PWS_ADDR_W 8
`define PWS_OFF_CMD 8'h00
`define PWS_OFF_STATUS 8'h04
`define PWS_OFF_CTRLW 8'h08
`define PWS_OFF_REV 8'h0C
`define PWS_OFF_PW0 8'h10
`define PWS_OFF_PW7 8'h2C
`define PWS_OFF_IDENT 8'h30
`define PWS_OFF_REVRD 8'h34

`define PWS_PW_WORDS 8
`define PWS_PW_BITS 256
`define PWS_BIT_ID 0
`define PWS_BIT_LEVEL 8
`define PWS_REV_MAX_VALID 16'hFFFD
`define PWS_REV_FACTORY 16'hFFFE
`define PWS_MASTER_FACTORY {32{8'h20}}
`define PWS_TRIES_INIT 5

`define PWS_CMD_SET 8'hF1
`define PWS_CMD_UNLOCK 8'hF2
`define PWS_CMD_PREP 8'hF3
`define PWS_CMD_ERASE 8'hF4
`define PWS_CMD_FREEZE 8'hF5
`define PWS_CMD_DISABLE 8'hF6
`define PWS_CMD_RD_SECT 8'h20
`define PWS_CMD_WR_SECT 8'h30
`define PWS_CMD_RD_DMA 8'hC8
`define PWS_CMD_WR_DMA 8'hCA
`define PWS_CMD_RD_VER 8'h40
`define PWS_CMD_FLUSH 8'hE7

`define PWS_RESP_OKAY 2'h0
`define PWS_RESP_SLVERR 2'h2

`endif

/* hdl/pwsec_pkg.sv */
// types shared by the password security block
package pwsec_pkg;

  typedef struct packed {
    logic lock_en;
    logic level_max;
    logic locked;
    logic frozen;
    logic [2:0] tries;
  } sec_state_t;

  typedef struct packed {
    logic done;
    logic aborted;
    logic [7:0] code;
  } cmd_result_t;

endpackage

/* hdl/drive_password_security_fsm.sv */
// password security state machine with an axi4-lite register port
//
// Notes on behaviour
// - storing a user password enables protection
// - locked device aborts media commands until unlocked
// - master password store keeps lock and level
// - high level: unlock also by master password
// - maximum level: master unlocks only via erase
// - after freeze, password changes refused until reset
// - factory master is all 20h, lock off
// - user password locks only from next reset
// - revisions 0000h-FFFDh valid, factory FFFEh
// - set sector: level, identifier, password, revision
// - user at high: unlock by user or master
// - user at maximum: unlock only by user
// - master set stores password and revision only
// - set password aborted when locked or frozen
// - unlock sector: identifier bit and password
// - master unlock: compare high, reject maximum
// - user unlock compares stored user password
// - mismatch while locked aborts and decrements counter
// - counter zero aborts unlock and erase
// - unlocked unlock keeps counter; frozen unlock aborts
// - lost user at maximum: erase with master
// - identify word 128 reports feature support
// - erase unit needs erase prepare just before
// - frozen rejects set, unlock, disable, erase
`timescale 1ns/10ps
`default_nettype none
`include "pwsec_map.svh"

module drive_password_security_fsm #(
  parameter int unsigned TRIES = `PWS_TRIES_INIT,
  parameter logic [15:0] SUPPORT_MASK = 16'h0001
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic factory_init,
  input wire logic [`PWS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`PWS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic media_denied,
  output logic erase_start,
  output pwsec_pkg::cmd_result_t cmd_result
);
  import pwsec_pkg::*;
  if (TRIES < 1 || TRIES > 7)
  begin : g_bad_tries
    $error("TRIES must lie in 1..7");
  end
  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  logic wr_fire;
  logic [`PWS_ADDR_W-1:0] wr_addr;
  logic wr_hit;
  logic cmd_fire;
  logic [31:0] ctrlw_reg;
  logic [31:0] rev_buf_reg;
  logic [31:0] pw_buf_reg [`PWS_PW_WORDS];
  logic [`PWS_PW_BITS-1:0] pw_flat;
  logic [1:0] bresp_reg;
  logic bvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic rvalid_reg;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [15:0] ident_word;
  sec_state_t st_reg;
  sec_state_t st_next;
  logic [`PWS_PW_BITS-1:0] user_pw_reg;
  logic [`PWS_PW_BITS-1:0] user_pw_next;
  logic [`PWS_PW_BITS-1:0] master_pw_reg;
  logic [`PWS_PW_BITS-1:0] master_pw_next;
  logic [15:0] rev_reg;
  logic [15:0] rev_next;
  logic prep_reg;
  logic prep_next;
  logic abort;
  logic erase_go;
  logic pw_match;
  logic sel_master;
  logic [7:0] cmd_code;
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction
  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign wr_addr = s_axi_awaddr;
  assign cmd_fire = wr_fire && (wr_addr == `PWS_OFF_CMD) && s_axi_wstrb[0];
  assign cmd_code = s_axi_wdata[7:0];
  assign wr_hit = (wr_addr == `PWS_OFF_CMD) || (wr_addr == `PWS_OFF_CTRLW)
    || (wr_addr == `PWS_OFF_REV)
    || (wr_addr >= `PWS_OFF_PW0 && wr_addr <= `PWS_OFF_PW7 && wr_addr[1:0] == 2'h0);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `PWS_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_hit ? `PWS_RESP_OKAY : `PWS_RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      bvalid_reg <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  // sector words of the host data transfer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrlw_reg <= 32'h0000_0000;
      rev_buf_reg <= 32'h0000_0000;
    end
    else if (wr_fire && wr_addr == `PWS_OFF_CTRLW)
    begin
      ctrlw_reg <= merge(ctrlw_reg, s_axi_wdata, s_axi_wstrb);
    end
    else if (wr_fire && wr_addr == `PWS_OFF_REV)
    begin
      rev_buf_reg <= merge(rev_buf_reg, s_axi_wdata, s_axi_wstrb);
    end
  end
  for (genvar i = 0; i < `PWS_PW_WORDS; i++)
  begin : g_pw
    localparam logic [`PWS_ADDR_W-1:0] OFF = `PWS_ADDR_W'(`PWS_OFF_PW0 + 4 * i);
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        pw_buf_reg[i] <= 32'h0000_0000;
      end
      else if (wr_fire && wr_addr == OFF)
      begin
        pw_buf_reg[i] <= merge(pw_buf_reg[i], s_axi_wdata, s_axi_wstrb);
      end
    end
    assign pw_flat[i*32 +: 32] = pw_buf_reg[i];
  end
  // read side
  assign ident_word = SUPPORT_MASK | {10'h000, st_reg.level_max, (st_reg.tries == 3'h0),
                      st_reg.frozen, st_reg.locked, st_reg.lock_en, 1'b0};
  always_comb
  begin
    rd_hit = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      `PWS_OFF_STATUS: rd_word = {22'h00_0000, cmd_result.done, cmd_result.aborted,
                                  1'b0, st_reg};
      `PWS_OFF_CTRLW: rd_word = ctrlw_reg;
      `PWS_OFF_REV: rd_word = rev_buf_reg;
      `PWS_OFF_IDENT: rd_word = {16'h0000, ident_word};
      `PWS_OFF_REVRD: rd_word = {16'h0000, rev_reg};
      `PWS_OFF_CMD: rd_word = {24'h00_0000, cmd_result.code};
      default: rd_hit = 1'b0;
    endcase
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `PWS_RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_reg)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_hit ? `PWS_RESP_OKAY : `PWS_RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      rvalid_reg <= 1'b0;
    end
  end
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  // ----------------------------------------------------------------
  // command interpreter
  // ----------------------------------------------------------------
  assign sel_master = ctrlw_reg[`PWS_BIT_ID];
  assign pw_match = sel_master ? (pw_flat == master_pw_reg) : (pw_flat == user_pw_reg);

  always_comb
  begin
    st_next = st_reg;
    user_pw_next = user_pw_reg;
    master_pw_next = master_pw_reg;
    rev_next = rev_reg;
    prep_next = cmd_fire ? 1'b0 : prep_reg;
    abort = 1'b0;
    erase_go = 1'b0;
    if (cmd_fire)
    begin
      unique case (cmd_code)
        `PWS_CMD_SET:
        begin
          if (st_reg.locked || st_reg.frozen)
          begin
            abort = 1'b1;
          end
          else if (sel_master)
          begin
            if (rev_buf_reg[15:0] > `PWS_REV_MAX_VALID)
            begin
              abort = 1'b1;
            end
            else
            begin
              master_pw_next = pw_flat;
              rev_next = rev_buf_reg[15:0];
            end
          end
          else
          begin
            user_pw_next = pw_flat;
            st_next.level_max = ctrlw_reg[`PWS_BIT_LEVEL];
            st_next.lock_en = 1'b1;
          end
        end
        `PWS_CMD_UNLOCK:
        begin
          if (st_reg.frozen || st_reg.tries == 3'h0)
          begin
            abort = 1'b1;
          end
          else if (sel_master && st_reg.level_max)
          begin
            abort = 1'b1;
          end
          else if (!pw_match)
          begin
            abort = 1'b1;
            if (st_reg.locked)
            begin
              st_next.tries = st_reg.tries - 3'h1;
            end
          end
          else
          begin
            st_next.locked = 1'b0;
          end
        end
        `PWS_CMD_PREP:
        begin
          if (st_reg.frozen)
          begin
            abort = 1'b1;
          end
          else
          begin
            prep_next = 1'b1;
          end
        end
        `PWS_CMD_ERASE:
        begin
          if (st_reg.frozen || st_reg.tries == 3'h0 || !prep_reg || !pw_match)
          begin
            abort = 1'b1;
          end
          else
          begin
            erase_go = 1'b1;
            st_next.locked = 1'b0;
            st_next.lock_en = 1'b0;
          end
        end
        `PWS_CMD_FREEZE:
        begin
          if (st_reg.locked)
          begin
            abort = 1'b1;
          end
          else
          begin
            st_next.frozen = 1'b1;
          end
        end
        `PWS_CMD_DISABLE:
        begin
          if (st_reg.locked || st_reg.frozen || !pw_match)
          begin
            abort = 1'b1;
          end
          else
          begin
            st_next.lock_en = 1'b0;
          end
        end
        `PWS_CMD_RD_SECT, `PWS_CMD_WR_SECT, `PWS_CMD_RD_DMA, `PWS_CMD_WR_DMA,
        `PWS_CMD_RD_VER, `PWS_CMD_FLUSH:
        begin
          abort = st_reg.locked;
        end
        default:
        begin
          abort = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_reg.lock_en <= factory_init ? 1'b0 : st_reg.lock_en;
      st_reg.level_max <= factory_init ? 1'b0 : st_reg.level_max;
      st_reg.locked <= factory_init ? 1'b0 : st_reg.lock_en;
      st_reg.frozen <= 1'b0;
      st_reg.tries <= 3'(TRIES);
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn && factory_init)
    begin
      master_pw_reg <= `PWS_MASTER_FACTORY;
      user_pw_reg <= '0;
      rev_reg <= `PWS_REV_FACTORY;
    end
    else if (aresetn)
    begin
      master_pw_reg <= master_pw_next;
      user_pw_reg <= user_pw_next;
      rev_reg <= rev_next;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prep_reg <= 1'b0;
      erase_start <= 1'b0;
      cmd_result <= '0;
    end
    else
    begin
      prep_reg <= prep_next;
      erase_start <= erase_go;
      if (cmd_fire)
      begin
        cmd_result <= '{done: 1'b1, aborted: abort, code: cmd_code};
      end
    end
  end

  assign media_denied = st_reg.locked;

endmodule
`default_nettype wire

/* bench/pwsec_checker.sv */
// assertions on the ports of the password security block
`timescale 1ns/10ps
`default_nettype none
`include "pwsec_map.svh"
module pwsec_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`PWS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_rvalid,
  input wire logic media_denied,
  input wire logic erase_start,
  input wire pwsec_pkg::cmd_result_t cmd_result
);
  import pwsec_pkg::*;
  // ---------------------------------------------
  // helper logic
  // ---------------------------------------------
  logic cw;
  logic ecw;
  logic ulk;
  logic frz_reg;
  logic [7:0] op;
  assign op = s_axi_wdata[7:0];
  assign cw = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && s_axi_wstrb[0]
    && s_axi_awaddr == `PWS_OFF_CMD;
  assign ecw = cw && op == `PWS_CMD_ERASE;
  assign ulk = cw && (op == `PWS_CMD_UNLOCK || op == `PWS_CMD_ERASE);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      frz_reg <= 1'b0;
    else if (cmd_result.done && !cmd_result.aborted && cmd_result.code == `PWS_CMD_FREEZE)
      frz_reg <= 1'b1;
  end
  // ---------------------------------------------
  // properties
  // ---------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_done;
    cw |=> cmd_result.done && cmd_result.code == $past(op);
  endproperty
  a_done: assert property (p_done)
    else $error("command result code wrong");
  property p_media;
    cw && media_denied && op inside {`PWS_CMD_RD_SECT, `PWS_CMD_WR_SECT, `PWS_CMD_RD_DMA,
      `PWS_CMD_WR_DMA, `PWS_CMD_RD_VER, `PWS_CMD_FLUSH} |=> cmd_result.aborted;
  endproperty
  a_media: assert property (p_media)
    else $error("media command ran while locked");
  property p_setlk;
    cw && media_denied && op == `PWS_CMD_SET |=> cmd_result.aborted;
  endproperty
  a_setlk: assert property (p_setlk)
    else $error("set accepted while locked");
  property p_frz;
    cw && frz_reg && op inside {`PWS_CMD_SET, `PWS_CMD_UNLOCK, `PWS_CMD_ERASE,
      `PWS_CMD_DISABLE} |=> cmd_result.aborted;
  endproperty
  a_frz: assert property (p_frz)
    else $error("command accepted while frozen");
  property p_esrc;
    erase_start |-> $past(ecw);
  endproperty
  a_esrc: assert property (p_esrc)
    else $error("erase start without erase command");
  property p_epulse;
    erase_start |=> !erase_start;
  endproperty
  a_epulse: assert property (p_epulse)
    else $error("erase start longer than one cycle");
  property p_lkrise;
    $rose(media_denied) |-> !$past(aresetn);
  endproperty
  a_lkrise: assert property (p_lkrise)
    else $error("lock set outside reset");
  property p_lkfall;
    $fell(media_denied) |-> $past(ulk) || !$past(aresetn);
  endproperty
  a_lkfall: assert property (p_lkfall)
    else $error("lock cleared without unlock");
  property p_rd;
    s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid;
  endproperty
  a_rd: assert property (p_rd)
    else $error("read answer late");
endmodule
`default_nettype wire

/* bench/host_model.sv */
// bus master standing in for the host
`timescale 1ns/10ps
`default_nettype none
`include "pwsec_map.svh"
module host_model (
  input wire logic aclk,
  output logic [`PWS_ADDR_W-1:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [`PWS_ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  logic [1:0] wresp = 2'h0;
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
  end
  // ---------------------------------------------
  // bus cycles
  // ---------------------------------------------
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1 || s_axi_wready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_awaddr <= ~a;
    s_axi_wdata <= ~d;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    wresp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // loads control word, revision and the 32 password bytes
  task pw(input logic [15:0] c, input logic [15:0] v, input logic [7:0] b);
    wr(`PWS_OFF_CTRLW, {16'h0, c});
    wr(`PWS_OFF_REV, {16'h0, v});
    for (int i = 0; i < 8; i++)
      wr(`PWS_OFF_PW0 + 8'(4 * i), {4{b}});
  endtask
endmodule
`default_nettype wire

/* bench/tb_top.sv */
// self-checking bench for the password security block
`timescale 1ns/10ps
`default_nettype none
`include "pwsec_map.svh"
module tb_top;
  import pwsec_pkg::*;
  typedef struct packed {
    logic [3:0] r;
    logic [15:0] c;
    logic [15:0] v;
    logic [7:0] b;
    logic [7:0] op;
    logic [3:0] ab;
    logic [3:0] dn;
    logic [3:0] t;
  } row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic factory_init = 1'b1;
  logic [`PWS_ADDR_W-1:0] s_axi_awaddr;
  logic [`PWS_ADDR_W-1:0] s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp;
  logic [1:0] s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic media_denied;
  logic erase_start;
  cmd_result_t cmd_result;
  logic [31:0] d;
  logic [1:0] rs;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int erases = 0;
  // reset, ctrl, rev, byte, opcode, aborted, denied, tries
  row_t rows [21] = '{
    64'h0_0001_0000_20_F2_0_0_5,
    64'h0_0001_FFFD_41_F1_0_0_5,
    64'h0_0001_FFFE_42_F1_1_0_5,
    64'h0_0000_0000_55_F1_0_0_5,
    64'h0_0000_0000_00_20_0_0_5,
    64'h0_0001_0000_41_F4_1_0_5,
    64'h0_0000_0000_00_F2_1_0_5,
    64'h1_0000_0000_00_20_1_1_5,
    64'h0_0000_0000_00_CA_1_1_5,
    64'h0_0000_0000_55_F1_1_1_5,
    64'h0_0001_0000_41_F2_0_0_5,
    64'h1_0000_0000_00_F2_1_1_4,
    64'h0_0000_0000_55_F2_0_0_4,
    64'h0_0100_0000_66_F1_0_0_4,
    64'h0_0000_0000_00_F5_0_0_4,
    64'h0_0000_0000_77_F1_1_0_4,
    64'h0_0000_0000_66_F2_1_0_4,
    64'h0_0000_0000_66_F6_1_0_4,
    64'h1_0001_0000_41_F2_1_1_5,
    64'h0_0000_0000_00_F3_0_1_5,
    64'h0_0001_0000_41_F4_0_0_5
  };
  always #4 aclk = ~aclk;
  host_model host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  drive_password_security_fsm dut (.aclk, .aresetn, .factory_init, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .media_denied, .erase_start, .cmd_result);
  // ---------------------------------------------
  // tasks
  // ---------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task rst(input logic f);
    @(posedge aclk);
    aresetn <= 1'b0;
    factory_init <= f;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    factory_init <= 1'b0;
  endtask
  task run(input logic [15:0] c, input logic [15:0] v, input logic [7:0] b, input logic [7:0] o);
    host.pw(c, v, b);
    host.wr(`PWS_OFF_CMD, {24'h0, o});
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    host.rd(a, d, rs);
    chk(d, e);
  endtask
  always @(posedge aclk)
  begin
    cyc++;
    if (erase_start === 1'b1)
      erases++;
    if (cyc == 30000)
    begin
      errors++;
      print_verdict();
    end
  end
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial
  begin
    rst(1'b1);
    foreach (rows[i])
    begin
      if (rows[i].r[0])
        rst(1'b0);
      run(rows[i].c, rows[i].v, rows[i].b, rows[i].op);
      chk(32'(cmd_result.aborted), 32'(rows[i].ab));
      chk(32'(media_denied), 32'(rows[i].dn));
      host.rd(`PWS_OFF_STATUS, d, rs);
      chk(32'(d[2:0]), 32'(rows[i].t));
    end
    rdc(`PWS_OFF_REVRD, 32'h0000FFFD);
    host.rd(`PWS_OFF_STATUS, d, rs);
    chk(32'(d[6]), 32'h0);
    chk(32'(erases), 32'h1);
    rst(1'b1);
    chk(32'(cmd_result), 32'h0);
    rdc(`PWS_OFF_STATUS, 32'h00000005);
    rdc(`PWS_OFF_REVRD, 32'h0000FFFE);
    rdc(`PWS_OFF_IDENT, 32'h00000001);
    host.rd(8'h40, d, rs);
    chk(32'(rs), 32'(`PWS_RESP_SLVERR));
    host.wr(8'h40, 32'h0);
    chk(32'(host.wresp), 32'(`PWS_RESP_SLVERR));
    run(16'h0001, 16'h0010, 8'h41, `PWS_CMD_SET);
    rst(1'b0);
    chk(32'(media_denied), 32'h0);
    rdc(`PWS_OFF_REVRD, 32'h00000010);
    run(16'h0000, 16'h0000, 8'h55, `PWS_CMD_SET);
    run(16'h0000, 16'h0000, 8'h55, `PWS_CMD_DISABLE);
    chk(32'(cmd_result.aborted), 32'h0);
    rst(1'b0);
    chk(32'(media_denied), 32'h0);
    run(16'h0000, 16'h0000, 8'h55, `PWS_CMD_SET);
    rst(1'b0);
    repeat (5) run(16'h0000, 16'h0000, 8'h00, `PWS_CMD_UNLOCK);
    run(16'h0000, 16'h0000, 8'h55, `PWS_CMD_UNLOCK);
    chk(32'(cmd_result.aborted), 32'h1);
    rdc(`PWS_OFF_IDENT, 32'h00000017);
    host.wr(`PWS_OFF_CMD, {24'h0, `PWS_CMD_PREP});
    host.wr(`PWS_OFF_CMD, {24'h0, `PWS_CMD_ERASE});
    chk(32'(cmd_result.aborted), 32'h1);
    chk(32'(media_denied), 32'h1);
    chk(32'(erases), 32'h1);
    print_verdict();
  end
endmodule
bind drive_password_security_fsm pwsec_checker chk (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_rvalid, .media_denied, .erase_start, .cmd_result);
`default_nettype wire
